// [src/reset_source_power_mode_ctrl.sv]
// What this block does
// - software trigger write causes full reset and sets soft reset flag
// - trigger bit self-clears after reset; writing zero does nothing
// - boot region select chooses application or programming region after soft reset
// - soft reset flag set only by soft reset; write one clears
// - fixed detector event sets fixed low-supply flag
// - selectable detector event sets selectable low-supply flag
// - level select 00/01/10/11 picks 2.0/2.4/3.7/4.2 V
// - fixed detector with reset enable resets system in run or idle
// - selectable detector reset enable resets; in sleep only if kept awake
// - system irq enable and detector irq enable raise system-flag interrupt
// - kept-awake selectable detector monitors in sleep, sets flag, wakes CPU
// - clearing selectable detector enable switches it off
// - watchdog overflow sets flag; with reset enable resets system
// - supply and watchdog flags hardware-set, write one clears, zero keeps
// - illegal address resets CPU and sets illegal address flag
// - nonstop watchdog counts in sleep and wakes CPU on overflow
// - halt request gates CPU clock, peripherals keep running
// - interrupt or reset ends idle; interrupt serviced then resume
// - RTC wake enable lets RTC overflow wake from sleep
// - slow oscillator with nonzero divider lowers system clock
// - sleep request stops oscillator until enabled wake or reset
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "rspmc_params.svh"
module reset_source_power_mode_ctrl #(
    parameter int RST_CYC = `RSPMC_RSTPULSE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // event sources
    input wire logic fixedDetEvent,
    input wire logic selectDetEvent,
    input wire logic wdOverflow,
    input wire logic illegalAddr,
    input wire logic rtcOverflow,
    input wire logic otherIrqWake,
    // controls to surroundings
    output logic cpuResetReq,
    output logic bootFromIsp,
    output logic cpuClkGate,
    output logic oscStop,
    output logic selectDetOn,
    output logic [1:0] selectLevel,
    output logic sysFlagIrq,
    output logic wdRunInSleep,
    output logic [1:0] oscSourceSel,
    output logic [2:0] clkDivSel
);
    // the pulse counter is eight bits wide, and a zero length would still give a one-cycle request pulse
    if (RST_CYC < 1 || RST_CYC > 255)
    begin : g_bad_rst_cyc
        $error("RST_CYC out of range");
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] flags_r;
    logic [7:0] pgm_r;
    logic [7:0] sup_r;
    logic [7:0] irq_r;
    logic [7:0] pwr_r;
    logic [7:0] clk_r;
    logic [7:0] rstCnt_r;
    rspmc_pkg::rspmc_mode_t mode_r;

    logic acc;
    logic wr;
    logic [7:0] wd;
    logic inSleep;
    logic fixRst;
    logic selRst;
    logic wdRst;
    logic softRst;
    logic anyRst;
    logic selDet;
    logic wake;
    logic irqLvl;

    assign acc = wbCyc && wbStb && !wbAck;
    assign wr = acc && wbWe && wbSel[0];
    assign wd = wbDatW[7:0];
    assign inSleep = (mode_r == rspmc_pkg::RSPMC_SLEEP);
    // detector switched off entirely when disabled, or asleep without keep-awake
    assign selDet = selectDetEvent && sup_r[`RSPMC_B_SELEN]
        && (!inSleep || sup_r[`RSPMC_B_KEEPSLP]);
    assign fixRst = fixedDetEvent && sup_r[`RSPMC_B_FIXRE] && !inSleep;
    assign selRst = selDet && sup_r[`RSPMC_B_SELRE];
    assign wdRst = wdOverflow && irq_r[`RSPMC_B_WDRE]
        && (!inSleep || irq_r[`RSPMC_B_NONSTOP]);
    assign softRst = wr && wbAdr == `RSPMC_ADR_PGMCTL && wd[`RSPMC_B_SWTRIG];
    assign anyRst = softRst || fixRst || selRst || wdRst || illegalAddr;
    assign irqLvl = irq_r[`RSPMC_B_SYSIE] && ((flags_r[`RSPMC_B_FIXLOW] && irq_r[`RSPMC_B_IE0])
        || (flags_r[`RSPMC_B_SELLOW] && irq_r[`RSPMC_B_IE1])
        || (flags_r[`RSPMC_B_WDOVF] && irq_r[`RSPMC_B_WDIE]));
    assign wake = irqLvl || otherIrqWake
        || (rtcOverflow && pwr_r[`RSPMC_B_RTCWK]);

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0000_0000;
        end
        else
        begin
            wbAck <= acc;
            if (acc && !wbWe)
            begin
                case (wbAdr)
                    `RSPMC_ADR_FLAGS: wbDatR <= {24'h000000, flags_r};
                    `RSPMC_ADR_PGMCTL: wbDatR <= {24'h000000, pgm_r};
                    `RSPMC_ADR_SUPCTL: wbDatR <= {24'h000000, sup_r};
                    `RSPMC_ADR_IRQCTL: wbDatR <= {24'h000000, irq_r};
                    `RSPMC_ADR_PWRCTL: wbDatR <= {24'h000000, pwr_r};
                    `RSPMC_ADR_CLKCTL: wbDatR <= {24'h000000, clk_r};
                    default: wbDatR <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    logic [7:0] setV;
    logic [7:0] clrV;
    always_comb
    begin
        setV = 8'h00;
        setV[`RSPMC_B_SOFTF] = softRst;
        setV[`RSPMC_B_FIXLOW] = fixedDetEvent && !inSleep;
        setV[`RSPMC_B_SELLOW] = selDet;
        setV[`RSPMC_B_WDOVF] = wdOverflow && (!inSleep || irq_r[`RSPMC_B_NONSTOP]);
        setV[`RSPMC_B_ILLADR] = illegalAddr;
        clrV = (wr && wbAdr == `RSPMC_ADR_FLAGS) ? wd : 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            flags_r <= 8'h00;
        else
            flags_r <= (flags_r & ~clrV) | setV;
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pgm_r <= 8'h00;
            sup_r <= `RSPMC_RST_SUPCTL;
            irq_r <= 8'h00;
            clk_r <= `RSPMC_RST_CLKCTL;
        end
        else if (wr)
        begin
            // trigger bit never stored: it reads back zero once the reset fires
            if (wbAdr == `RSPMC_ADR_PGMCTL)
                pgm_r <= wd & 8'hC0;
            if (wbAdr == `RSPMC_ADR_SUPCTL)
                sup_r <= (wd & 8'hBE) | 8'h01;
            if (wbAdr == `RSPMC_ADR_IRQCTL)
                irq_r <= wd;
            if (wbAdr == `RSPMC_ADR_CLKCTL)
                clk_r <= wd & 8'h1F;
        end
    end

    // ----------------------------------------
    // power mode
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_r <= rspmc_pkg::RSPMC_RUN;
            pwr_r <= 8'h00;
        end
        else if (rstCnt_r != 8'h00 || anyRst)
        begin
            mode_r <= rspmc_pkg::RSPMC_RUN;
            pwr_r <= pwr_r & 8'hFC;
        end
        else
        begin
            case (mode_r)
                rspmc_pkg::RSPMC_RUN:
                begin
                    if (wr && wbAdr == `RSPMC_ADR_PWRCTL)
                    begin
                        pwr_r <= wd & 8'h0B;
                        if (wd[`RSPMC_B_SLEEP])
                            mode_r <= rspmc_pkg::RSPMC_SLEEP;
                        else if (wd[`RSPMC_B_IDLE])
                            mode_r <= rspmc_pkg::RSPMC_IDLE;
                    end
                end
                rspmc_pkg::RSPMC_IDLE, rspmc_pkg::RSPMC_SLEEP:
                begin
                    if (wake)
                    begin
                        mode_r <= rspmc_pkg::RSPMC_RUN;
                        pwr_r <= pwr_r & 8'hFC;
                    end
                end
                default: mode_r <= rspmc_pkg::RSPMC_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // reset pulse and outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            rstCnt_r <= 8'h00;
        else if (anyRst)
            rstCnt_r <= 8'(RST_CYC);
        else if (rstCnt_r != 8'h00)
            rstCnt_r <= rstCnt_r - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cpuResetReq <= 1'b0;
            bootFromIsp <= 1'b0;
            cpuClkGate <= 1'b0;
            oscStop <= 1'b0;
            selectDetOn <= 1'b0;
            selectLevel <= 2'h0;
            sysFlagIrq <= 1'b0;
            wdRunInSleep <= 1'b0;
            oscSourceSel <= 2'h0;
            clkDivSel <= 3'h0;
        end
        else
        begin
            cpuResetReq <= anyRst || rstCnt_r > 8'h01;
            if (softRst)
                bootFromIsp <= wd[`RSPMC_B_BOOTSEL];
            cpuClkGate <= mode_r != rspmc_pkg::RSPMC_RUN;
            oscStop <= inSleep;
            selectDetOn <= sup_r[`RSPMC_B_SELEN] && (!inSleep || sup_r[`RSPMC_B_KEEPSLP]);
            selectLevel <= sup_r[5:4];
            sysFlagIrq <= irqLvl;
            wdRunInSleep <= irq_r[`RSPMC_B_NONSTOP];
            oscSourceSel <= clk_r[4:3];
            clkDivSel <= clk_r[2:0];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_softflag;
        @(posedge clk) disable iff (srst) softRst |=> flags_r[`RSPMC_B_SOFTF] && cpuResetReq;
    endproperty
    a_softflag: assert property (p_softflag) else $error("soft reset flag or reset missing");

    property p_trigclr;
        @(posedge clk) disable iff (srst) softRst |=> !pgm_r[`RSPMC_B_SWTRIG];
    endproperty
    a_trigclr: assert property (p_trigclr) else $error("trigger bit stuck");

    property p_setwins;
        @(posedge clk) disable iff (srst) (selDet && wr && wbAdr == `RSPMC_ADR_FLAGS)
            |=> flags_r[`RSPMC_B_SELLOW];
    endproperty
    a_setwins: assert property (p_setwins) else $error("event lost to clear");

    property p_setwinsfix;
        @(posedge clk) disable iff (srst) (fixedDetEvent && !inSleep && wr && wbAdr == `RSPMC_ADR_FLAGS)
            |=> flags_r[`RSPMC_B_FIXLOW];
    endproperty
    a_setwinsfix: assert property (p_setwinsfix) else $error("fixed detector event lost to clear");

    property p_wdrst;
        @(posedge clk) disable iff (srst) (wdOverflow && irq_r[`RSPMC_B_WDRE] && !inSleep)
            |=> cpuResetReq && flags_r[`RSPMC_B_WDOVF];
    endproperty
    a_wdrst: assert property (p_wdrst) else $error("watchdog reset missing");

    property p_illegal;
        @(posedge clk) disable iff (srst) illegalAddr |=> cpuResetReq && flags_r[`RSPMC_B_ILLADR];
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal address reset missing");

    property p_zerokeep;
        @(posedge clk) disable iff (srst) (wr && wbAdr == `RSPMC_ADR_FLAGS && !wd[`RSPMC_B_WDOVF]
            && flags_r[`RSPMC_B_WDOVF]) |=> flags_r[`RSPMC_B_WDOVF];
    endproperty
    a_zerokeep: assert property (p_zerokeep) else $error("zero write cleared flag");

    property p_selsleep;
        @(posedge clk) disable iff (srst) (inSleep && !sup_r[`RSPMC_B_KEEPSLP]) |-> !selRst;
    endproperty
    a_selsleep: assert property (p_selsleep) else $error("detector reset while asleep");

    property p_idlewake;
        @(posedge clk) disable iff (srst) (mode_r == rspmc_pkg::RSPMC_IDLE && wake)
            |=> ##1 !cpuClkGate;
    endproperty
    a_idlewake: assert property (p_idlewake) else $error("idle not ended");

    property p_wrzero;
        @(posedge clk) disable iff (srst) (wr && wbAdr == `RSPMC_ADR_PGMCTL && !wd[`RSPMC_B_SWTRIG]
            && !anyRst && rstCnt_r == 8'h00) |=> !cpuResetReq;
    endproperty
    a_wrzero: assert property (p_wrzero) else $error("zero trigger write caused reset");

    property p_bootsel;
        @(posedge clk) disable iff (srst) (softRst && wd[`RSPMC_B_BOOTSEL]) |=> bootFromIsp;
    endproperty
    a_bootsel: assert property (p_bootsel) else $error("boot region not latched");

    property p_pulseend;
        @(posedge clk) disable iff (srst) (rstCnt_r == 8'h01 && !anyRst) |=> !cpuResetReq;
    endproperty
    a_pulseend: assert property (p_pulseend) else $error("reset request overran");

    property p_sleepwake;
        @(posedge clk) disable iff (srst) (inSleep && wake) |=> ##1 !oscStop;
    endproperty
    a_sleepwake: assert property (p_sleepwake) else $error("sleep not ended by wake");

    property p_irqfix;
        @(posedge clk) disable iff (srst) (irq_r[`RSPMC_B_SYSIE] && irq_r[`RSPMC_B_IE0]
            && flags_r[`RSPMC_B_FIXLOW]) |=> sysFlagIrq;
    endproperty
    a_irqfix: assert property (p_irqfix) else $error("system flag interrupt missing");
endmodule // reset_source_power_mode_ctrl
`default_nettype wire

// [src/rspmc_params.svh]
`ifndef RSPMC_PARAMS_SVH
`define RSPMC_PARAMS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define RSPMC_ADR_FLAGS 8'h97
`define RSPMC_ADR_PGMCTL 8'hE7
`define RSPMC_ADR_SUPCTL 8'h44
`define RSPMC_ADR_IRQCTL 8'h8E
`define RSPMC_ADR_PWRCTL 8'h87
`define RSPMC_ADR_CLKCTL 8'h40
// ----------------------------------------
// field positions
// ----------------------------------------
`define RSPMC_B_SOFTF 7
`define RSPMC_B_SELLOW 2
`define RSPMC_B_FIXLOW 1
`define RSPMC_B_WDOVF 0
`define RSPMC_B_ILLADR 3
`define RSPMC_B_BOOTSEL 6
`define RSPMC_B_SWTRIG 5
`define RSPMC_B_KEEPSLP 7
`define RSPMC_B_SELRE 3
`define RSPMC_B_SELEN 2
`define RSPMC_B_FIXRE 1
`define RSPMC_B_WDRE 6
`define RSPMC_B_NONSTOP 5
`define RSPMC_B_SYSIE 4
`define RSPMC_B_IE1 2
`define RSPMC_B_IE0 1
`define RSPMC_B_WDIE 0
`define RSPMC_B_RTCWK 3
`define RSPMC_B_SLEEP 1
`define RSPMC_B_IDLE 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define RSPMC_RST_SUPCTL 8'h05
`define RSPMC_RST_CLKCTL 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define RSPMC_CLK_MHZ 250
`define RSPMC_RSTPULSE_NS 24
`define RSPMC_RSTPULSE_CYC ((`RSPMC_RSTPULSE_NS * `RSPMC_CLK_MHZ + 999) / 1000)
`endif

// [src/rspmc_pkg.sv]
package rspmc_pkg;
    typedef enum logic [2:0] {
        RSPMC_RUN = 3'b001,
        RSPMC_IDLE = 3'b010,
        RSPMC_SLEEP = 3'b100
    } rspmc_mode_t;
endpackage

// [verification/reset_source_power_mode_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module reset_source_power_mode_ctrl_test;
// ----------------------------------------
// signals
// ----------------------------------------
localparam int RC = 6;
logic clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
logic fixedDetEvent = 0, selectDetEvent = 0, wdOverflow = 0;
logic illegalAddr = 0, rtcOverflow = 0, otherIrqWake = 0;
logic [7:0] wbAdr = 0, rd;
logic [3:0] wbSel = 0;
logic [31:0] wbDatW = 0, wbDatR;
logic cpuResetReq, bootFromIsp, cpuClkGate, oscStop, selectDetOn, sysFlagIrq, wdRunInSleep;
logic [1:0] selectLevel, oscSourceSel;
logic [2:0] clkDivSel;
int n_mismatch = 0;
int n_checks = 0;
int cnt;
reset_source_power_mode_ctrl #(.RST_CYC(RC)) uut (.clk(clk), .srst(srst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .fixedDetEvent(fixedDetEvent), .selectDetEvent(selectDetEvent),
    .wdOverflow(wdOverflow), .illegalAddr(illegalAddr), .rtcOverflow(rtcOverflow),
    .otherIrqWake(otherIrqWake), .cpuResetReq(cpuResetReq), .bootFromIsp(bootFromIsp),
    .cpuClkGate(cpuClkGate), .oscStop(oscStop), .selectDetOn(selectDetOn),
    .selectLevel(selectLevel), .sysFlagIrq(sysFlagIrq), .wdRunInSleep(wdRunInSleep),
    .oscSourceSel(oscSourceSel), .clkDivSel(clkDivSel));
initial
begin
    forever #2 clk = ~clk;
end
// ----------------------------------------
// helpers
// ----------------------------------------
task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
        n_mismatch++;
        $display("FAIL %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clk);
endtask
// request held until ack is sampled; read data taken at that edge
task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'h1;
    wbDatW <= {24'h000000, d};
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    rd = wbDatR[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
endtask
task automatic ev(input int k);
    case (k)
        0: fixedDetEvent <= 1'b1;
        1: wdOverflow <= 1'b1;
        2: illegalAddr <= 1'b1;
        3: selectDetEvent <= 1'b1;
        4: rtcOverflow <= 1'b1;
        default: otherIrqWake <= 1'b1;
    endcase
    @(posedge clk);
    {fixedDetEvent, wdOverflow, illegalAddr, selectDetEvent, rtcOverflow, otherIrqWake} <= 6'h00;
endtask
// counts reset-request cycles over a window longer than any pulse
task automatic rstCount();
    cnt = 0;
    repeat (24)
    begin
        @(posedge clk);
        if (cpuResetReq === 1'b1) cnt++;
    end
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_regs();
    wb(0, 8'h44, 8'h00);
    chk("supply ctl", 8'h05, rd);
    wb(0, 8'h97, 8'h00);
    chk("flags", 8'h00, rd);
    wb(0, 8'h10, 8'h00);
    chk("unmapped", 8'h00, rd);
    $display("test regs done");
endtask
task automatic t_soft();
    fork wb(1, 8'hE7, 8'h60); rstCount(); join
    chk("soft reset len", RC[7:0], cnt[7:0]);
    chk("boot isp", 8'h01, {7'h00, bootFromIsp});
    wb(0, 8'hE7, 8'h00);
    chk("trigger bit", 8'h00, rd & 8'h20);
    wb(0, 8'h97, 8'h00);
    chk("soft flag", 8'h80, rd & 8'h80);
    wb(1, 8'h97, 8'h00);
    wb(0, 8'h97, 8'h00);
    chk("soft flag kept", 8'h80, rd & 8'h80);
    wb(1, 8'h97, 8'h80);
    wb(0, 8'h97, 8'h00);
    chk("soft flag clr", 8'h00, rd & 8'h80);
    fork wb(1, 8'hE7, 8'h20); rstCount(); join
    chk("boot app", 8'h00, {7'h00, bootFromIsp});
    fork wb(1, 8'hE7, 8'h00); rstCount(); join
    chk("write zero", 8'h00, cnt[7:0]);
    $display("test soft done");
endtask
task automatic t_src();
    logic [7:0] ca[4] = '{8'h44, 8'h8E, 8'h44, 8'h44};
    logic [7:0] cd[4] = '{8'h07, 8'h40, 8'h05, 8'h8D};
    logic [7:0] fl[4] = '{8'h02, 8'h01, 8'h08, 8'h04};
    for (int k = 0; k < 4; k++)
    begin
        wb(1, 8'h97, 8'hFF);
        wb(1, ca[k], cd[k]);
        if (k == 3) wb(1, 8'h87, 8'h02);
        fork ev(k); rstCount(); join
        chk("source reset len", RC[7:0], cnt[7:0]);
        wb(0, 8'h97, 8'h00);
        chk("source flag", fl[k], rd & fl[k]);
    end
    chk("awake after", 8'h00, {7'h00, oscStop});
    $display("test sources done");
endtask
task automatic t_level();
    for (int i = 0; i < 4; i++)
    begin
        wb(1, 8'h44, {2'b00, i[1:0], 4'h5});
        chk("level", {6'h00, i[1:0]}, {6'h00, selectLevel});
        chk("det on", 8'h01, {7'h00, selectDetOn});
    end
    wb(1, 8'h44, 8'h01);
    chk("det off", 8'h00, {7'h00, selectDetOn});
    $display("test level done");
endtask
task automatic t_irq();
    wb(1, 8'h44, 8'h05);
    wb(1, 8'h97, 8'hFF);
    wb(1, 8'h8E, 8'h12);
    ev(0);
    tick(2);
    chk("sys irq", 8'h01, {7'h00, sysFlagIrq});
    fork wb(1, 8'h97, 8'h02); ev(0); join
    wb(0, 8'h97, 8'h00);
    chk("set wins", 8'h02, rd & 8'h02);
    wb(1, 8'h97, 8'h02);
    tick(2);
    chk("sys irq off", 8'h00, {7'h00, sysFlagIrq});
    wb(0, 8'h97, 8'h00);
    chk("flag clr", 8'h00, rd & 8'h02);
    $display("test irq done");
endtask
task automatic t_power();
    wb(1, 8'h87, 8'h01);
    tick(2);
    chk("idle gate", 8'h01, {7'h00, cpuClkGate});
    ev(5);
    tick(4);
    chk("idle exit", 8'h00, {7'h00, cpuClkGate});
    wb(1, 8'h87, 8'h0A);
    tick(2);
    chk("sleep osc", 8'h01, {7'h00, oscStop});
    ev(4);
    tick(4);
    chk("rtc wake", 8'h00, {7'h00, oscStop});
    wb(0, 8'h87, 8'h00);
    chk("sleep bit", 8'h00, rd & 8'h02);
    wb(1, 8'h40, 8'h0B);
    chk("clk ctl", 8'h0B, {3'h0, oscSourceSel, clkDivSel});
    wb(1, 8'h8E, 8'h20);
    chk("wd nonstop", 8'h01, {7'h00, wdRunInSleep});
    $display("test power done");
endtask
// ----------------------------------------
// run
// ----------------------------------------
task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
initial
begin
    tick(10);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_soft();
    t_src();
    t_level();
    t_irq();
    t_power();
    end_of_test();
end
// all tests need well under 3000 cycles
initial
begin
    #80000;
    n_mismatch++;
    end_of_test();
end
endmodule // reset_source_power_mode_ctrl_test
`default_nettype wire
